// ---- ldcos_pkg.sv ----
// Package for the line data-check and overrun sense logic.
package ldcos_pkg;

    // ----------------------------------------------------------------
    // Sense bit positions and widths
    // ----------------------------------------------------------------
    localparam int unsigned SENSE_W        = 8;
    localparam int unsigned SENSE_DCHK_BIT = 4;
    localparam int unsigned SENSE_OVRN_BIT = 5;
    localparam int unsigned CHAR_W         = 8;
    localparam int unsigned WORD_BYTES     = 4;
    localparam int unsigned WORD_W         = CHAR_W * WORD_BYTES;
    localparam int unsigned FIFO_DEPTH     = 8;
    localparam logic [1:0]  BYTE_LAST      = 2'h3;
    localparam logic [7:0]  SENSE_RESET    = 8'h00;

    // ----------------------------------------------------------------
    // Line types and commands
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        LDCOS_LT_SS1  = 4'h1,
        LDCOS_LT_SS2  = 4'h2,
        LDCOS_LT_TG2  = 4'h4,
        LDCOS_LT_TG1  = 4'h8
    } ldcos_line_t;

    typedef enum logic [2:0] {
        LDCOS_CMD_NONE    = 3'h0,
        LDCOS_CMD_WRITE   = 3'h1,
        LDCOS_CMD_READ    = 3'h2,
        LDCOS_CMD_INHIBIT = 3'h3,
        LDCOS_CMD_POLL    = 3'h4,
        LDCOS_CMD_SEARCH  = 3'h5,
        LDCOS_CMD_WRAP    = 3'h6
    } ldcos_cmd_t;

    typedef enum logic [2:0] {
        LDCOS_ST_IDLE = 3'h1,
        LDCOS_ST_SS   = 3'h2,
        LDCOS_ST_BSC  = 3'h4
    } ldcos_state_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        start;
        ldcos_cmd_t  cmd;
        logic        bsc;
        ldcos_line_t line;
        logic        tg_opt;
        logic        ascii_opt;
        logic        transp;
    } ldcos_cmd_s_t;

    typedef struct packed {
        logic vrc_err;
        logic lrc_err;
        logic crc_err;
        logic echo_err;
        logic brk_rx;
        logic stop_space;
        logic neg_resp;
        logic resp_ok;
        logic resp_done;
        logic bad_ctl_seq;
        logic cmd_end;
    } ldcos_evt_t;

endpackage

// ---- ldcos_fifo.sv ----
// Parameterised valid/ready FIFO.
`timescale 1ns/10ps
`default_nettype none
module ldcos_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // Status
    output logic                  empty
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } ldcos_fifo_st_t;

    ldcos_fifo_st_t   st_r;
    ldcos_fifo_st_t   st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign empty     = ~out_valid;
    assign out_data  = mem[st_r.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[st_r.wp] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ---- ldcos_pack.sv ----
// Packs received characters into channel buffer words.
`timescale 1ns/10ps
`default_nettype none
module ldcos_pack
    import ldcos_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              reset_n,
    // Control
    input  wire logic              clear,
    // Character input
    input  wire logic              char_valid,
    input  wire logic [CHAR_W-1:0] char_data,
    // Word output
    output logic                   word_valid,
    output logic [WORD_W-1:0]      word_data
);
    typedef struct packed {
        logic [1:0]        idx;
        logic [WORD_W-1:0] word;
        logic              vld;
    } ldcos_pack_st_t;

    ldcos_pack_st_t st_r;
    ldcos_pack_st_t st_nxt;

    assign word_valid = st_r.vld;
    assign word_data  = st_r.word;

    // First byte lands in the top lane; a partial word is dropped on clear.
    always_comb begin
        st_nxt     = st_r;
        st_nxt.vld = 1'b0;
        if (clear) begin
            st_nxt.idx = '0;
        end else if (char_valid) begin
            st_nxt.word[WORD_W-1-CHAR_W*st_r.idx -: CHAR_W] = char_data;
            st_nxt.idx = st_r.idx + 2'h1;
            st_nxt.vld = (st_r.idx == BYTE_LAST);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- ldcos_sense.sv ----
// Data-check and overrun sense bit logic for one communication line.
`timescale 1ns/10ps
`default_nettype none
module ldcos_sense
    import ldcos_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                reset_n,
    // Command from the channel
    input  wire ldcos_pkg::ldcos_cmd_s_t cmd_in,
    input  wire logic                sense_rd,
    // Line events
    input  wire ldcos_pkg::ldcos_evt_t   evt_in,
    // Received data from the line
    input  wire logic                char_valid,
    input  wire logic [ldcos_pkg::CHAR_W-1:0] char_data,
    // Channel data service
    output logic                     svc_req,
    input  wire logic                svc_ack,
    output logic [ldcos_pkg::WORD_W-1:0] svc_data,
    output logic [ldcos_pkg::CHAR_W-1:0] svc_char,
    // Sense
    output logic [ldcos_pkg::SENSE_W-1:0] sense
);
    import ldcos_pkg::*;

    typedef struct packed {
        ldcos_state_t     st;
        ldcos_cmd_s_t     cmd;
        logic             dchk;
        logic             ovrn;
        logic             ss_pend;
        logic [CHAR_W-1:0] ss_char;
    } ldcos_st_t;

    ldcos_st_t        st_r;
    ldcos_st_t        st_nxt;
    logic             dchk_set;
    logic             ovrn_set;
    logic             is_ss;
    logic             is_bsc;
    logic             rd_like;
    logic             type1;
    logic             type2;
    logic             wrd_valid;
    logic [WORD_W-1:0] wrd_data;
    logic             fifo_in_ready;
    logic             fifo_valid;
    logic             fifo_empty;
    logic             new_cmd;
    logic             pack_clear;

    assign new_cmd    = cmd_in.start;
    assign pack_clear = new_cmd | (st_r.st != LDCOS_ST_BSC);
    assign is_ss      = (st_r.st == LDCOS_ST_SS);
    assign is_bsc     = (st_r.st == LDCOS_ST_BSC);
    assign type1      = (st_r.cmd.line == LDCOS_LT_SS1);
    assign type2      = (st_r.cmd.line == LDCOS_LT_SS2);
    assign rd_like    = (st_r.cmd.cmd == LDCOS_CMD_READ) | (st_r.cmd.cmd == LDCOS_CMD_INHIBIT);

    // ----------------------------------------------------------------
    // Synchronous word path
    // ----------------------------------------------------------------
    ldcos_pack u_pack (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .clear      (pack_clear),
        .char_valid (char_valid & is_bsc),
        .char_data  (char_data),
        .word_valid (wrd_valid),
        .word_data  (wrd_data)
    );

    // The buffer holds up to 8 words, but a second word arriving before the first is taken means the channel fell behind.
    ldcos_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .in_valid  (wrd_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (wrd_data),
        .out_valid (fifo_valid),
        .out_ready (svc_ack & is_bsc),
        .out_data  (svc_data),
        .empty     (fifo_empty)
    );

    assign svc_req  = is_bsc ? !fifo_empty : st_r.ss_pend;
    assign svc_char = st_r.ss_char;

    // ----------------------------------------------------------------
    // Error decode
    // ----------------------------------------------------------------
    always_comb begin
        dchk_set = 1'b0;
        ovrn_set = 1'b0;
        if (is_ss) begin
            unique case (st_r.cmd.cmd)
                LDCOS_CMD_WRITE: begin
                    if (type1 && (evt_in.vrc_err || (st_r.cmd.tg_opt && evt_in.echo_err))) begin
                        dchk_set = 1'b1;
                    end
                    if (type2 && evt_in.vrc_err) begin
                        dchk_set = 1'b1;
                    end
                    if (st_r.cmd.line == LDCOS_LT_TG2 && evt_in.brk_rx) begin
                        dchk_set = 1'b1;
                    end
                    if (st_r.cmd.line == LDCOS_LT_TG1 && evt_in.echo_err) begin
                        dchk_set = 1'b1;
                    end
                end
                LDCOS_CMD_READ, LDCOS_CMD_INHIBIT: begin
                    if (type1 && (evt_in.vrc_err || evt_in.lrc_err || evt_in.neg_resp)) begin
                        dchk_set = 1'b1;
                    end
                    if (type2 && (evt_in.vrc_err || evt_in.neg_resp)) begin
                        dchk_set = 1'b1;
                    end
                    if (st_r.cmd.line != LDCOS_LT_TG1 && evt_in.stop_space) begin
                        dchk_set = 1'b1;
                    end
                end
                LDCOS_CMD_SEARCH: begin
                    if (st_r.cmd.line == LDCOS_LT_TG1 && evt_in.stop_space) begin
                        dchk_set = 1'b1;
                    end
                end
                LDCOS_CMD_POLL: begin
                    if ((type1 || type2) && (evt_in.vrc_err || evt_in.stop_space)) begin
                        dchk_set = 1'b1;
                    end
                    if (type1 && st_r.cmd.tg_opt && evt_in.echo_err) begin
                        dchk_set = 1'b1;
                    end
                    if (evt_in.resp_done && !evt_in.resp_ok) begin
                        dchk_set = 1'b1;
                    end
                end
                LDCOS_CMD_WRAP: begin
                    if ((type1 || type2) && evt_in.vrc_err) begin
                        dchk_set = 1'b1;
                    end
                end
                default: begin
                end
            endcase
            // A character arriving while the previous one waits replaces it; the waiting one is lost.
            if (st_r.cmd.cmd == LDCOS_CMD_READ && char_valid && st_r.ss_pend && !svc_ack) begin
                ovrn_set = 1'b1;
            end
            if (st_r.cmd.cmd == LDCOS_CMD_INHIBIT && evt_in.cmd_end && st_r.ss_pend) begin
                ovrn_set = 1'b1;
            end
        end else if (is_bsc) begin
            if (st_r.cmd.cmd == LDCOS_CMD_READ) begin
                if (evt_in.crc_err || evt_in.lrc_err) begin
                    dchk_set = 1'b1;
                end
                if (st_r.cmd.transp && evt_in.bad_ctl_seq) begin
                    dchk_set = 1'b1;
                end
            end
            if (rd_like_bsc(st_r.cmd.cmd) && st_r.cmd.ascii_opt && evt_in.vrc_err) begin
                dchk_set = 1'b1;
            end
            // Second word fills while the first still waits for the channel.
            if (rd_like_bsc(st_r.cmd.cmd) && wrd_valid && fifo_valid && !svc_ack) begin
                ovrn_set = 1'b1;
            end
        end
    end

    function automatic logic rd_like_bsc(input ldcos_cmd_t c);
        rd_like_bsc = (c == LDCOS_CMD_READ) || (c == LDCOS_CMD_SEARCH);
    endfunction

    // ----------------------------------------------------------------
    // State update
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // The channel may still take the last character after command end.
        if (svc_ack && !is_bsc) begin
            st_nxt.ss_pend = 1'b0;
        end
        if (is_ss && rd_like && char_valid) begin
            st_nxt.ss_pend = 1'b1;
            st_nxt.ss_char = char_data;
        end
        // Clearing happens first so an error in the same cycle as a sense read still lands.
        if (sense_rd || new_cmd) begin
            st_nxt.dchk = 1'b0;
            st_nxt.ovrn = 1'b0;
        end
        if (new_cmd) begin
            st_nxt.cmd     = cmd_in;
            st_nxt.ss_pend = 1'b0;
            if (cmd_in.cmd == LDCOS_CMD_NONE) begin
                st_nxt.st = LDCOS_ST_IDLE;
            end else if (cmd_in.bsc) begin
                st_nxt.st = LDCOS_ST_BSC;
            end else begin
                st_nxt.st = LDCOS_ST_SS;
            end
        end else begin
            if (dchk_set) begin
                st_nxt.dchk = 1'b1;
            end
            if (ovrn_set) begin
                st_nxt.ovrn = 1'b1;
            end
            if (is_ss && evt_in.cmd_end) begin
                st_nxt.st = LDCOS_ST_IDLE;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{st: LDCOS_ST_IDLE, cmd: '0, dchk: 1'b0, ovrn: 1'b0,
                      ss_pend: 1'b0, ss_char: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        sense                 = SENSE_RESET;
        sense[SENSE_DCHK_BIT] = st_r.dchk;
        sense[SENSE_OVRN_BIT] = st_r.ovrn;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_ss_read;
        is_ss && st_r.cmd.cmd == LDCOS_CMD_READ && !new_cmd;
    endsequence

    AST_WR_T1: assert property (@(posedge mclk) disable iff (!reset_n)
        is_ss && !new_cmd && st_r.cmd.cmd == LDCOS_CMD_WRITE && type1 && evt_in.vrc_err
        |=> sense[SENSE_DCHK_BIT]) else $error("write parity did not set data check");
    AST_WR_BRK: assert property (@(posedge mclk) disable iff (!reset_n)
        is_ss && !new_cmd && st_r.cmd.cmd == LDCOS_CMD_WRITE
        && st_r.cmd.line == LDCOS_LT_TG2 && evt_in.brk_rx
        |=> st_r.dchk) else $error("break did not set data check");
    AST_RD_T1: assert property (@(posedge mclk) disable iff (!reset_n)
        is_ss && !new_cmd && rd_like && type1 && evt_in.lrc_err
        |=> st_r.dchk) else $error("longitudinal error missed");
    AST_RD_T2: assert property (@(posedge mclk) disable iff (!reset_n)
        is_ss && !new_cmd && rd_like && type2 && evt_in.neg_resp
        |=> st_r.dchk) else $error("negative reply missed");
    AST_POLL: assert property (@(posedge mclk) disable iff (!reset_n)
        is_ss && !new_cmd && st_r.cmd.cmd == LDCOS_CMD_POLL && evt_in.resp_done
        && !evt_in.resp_ok |=> st_r.dchk) else $error("bad poll reply missed");
    AST_BSC_BLK: assert property (@(posedge mclk) disable iff (!reset_n)
        is_bsc && !new_cmd && st_r.cmd.cmd == LDCOS_CMD_READ && evt_in.crc_err
        |=> st_r.dchk) else $error("block check missed");
    AST_SS_OVRN: assert property (@(posedge mclk) disable iff (!reset_n)
        s_ss_read ##0 (char_valid && st_r.ss_pend && !svc_ack)
        |=> sense[SENSE_OVRN_BIT]) else $error("start/stop overrun missed");
    AST_BSC_OVRN: assert property (@(posedge mclk) disable iff (!reset_n)
        is_bsc && !new_cmd && st_r.cmd.cmd == LDCOS_CMD_SEARCH && wrd_valid
        && fifo_valid && !svc_ack |=> st_r.ovrn) else $error("word overrun missed");
    AST_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        st_r.ovrn && !sense_rd && !new_cmd |=> st_r.ovrn [*1])
        else $error("overrun dropped without clear");
    AST_CLR: assert property (@(posedge mclk) disable iff (!reset_n)
        new_cmd |=> !st_r.dchk && !st_r.ovrn) else $error("new command did not clear sense");
    AST_FIFO_ROOM: assert property (@(posedge mclk) disable iff (!reset_n)
        is_bsc && wrd_valid |-> fifo_in_ready) else $error("word buffer refused a word");
endmodule
`default_nettype wire

// ---- ldcos_chan_model.sv ----
// Channel partner model that takes data-service requests after a set delay.
`timescale 1ns/10ps
`default_nettype none
module ldcos_chan_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // Service handshake
    input  wire logic       svc_req,
    output logic            svc_ack,
    // Cycles before a request is taken; all ones stalls the channel
    input  wire logic [7:0] ack_dly
);
    logic [7:0] wait_r;
    // ------------------------------------------------------------
    // Request service
    // ------------------------------------------------------------
    // The ack never repeats on the next edge, because it is gated by !svc_ack: the device drops its
    // request only at the edge that takes the ack.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            svc_ack <= 1'b0;
            wait_r  <= 8'h00;
        end else begin
            svc_ack <= 1'b0;
            if (svc_req && !svc_ack && ack_dly != 8'hFF) begin
                if (wait_r >= ack_dly) begin
                    svc_ack <= 1'b1;
                    wait_r  <= 8'h00;
                end else begin
                    wait_r <= wait_r + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- ldcos_sense_tb.sv ----
// Self-checking testbench for the data-check and overrun sense logic.
`timescale 1ns/10ps
`default_nettype none
module ldcos_sense_tb;
    import ldcos_pkg::*;
    typedef struct packed {
        ldcos_cmd_t  cmd;
        logic        bsc;
        ldcos_line_t line;
        logic        tg;
        logic        asc;
        logic        tr;
        logic [10:0] ev;
        logic        dc;
    } ldcos_case_t;
    localparam int NCASE = 22;
    localparam ldcos_case_t CASES [NCASE] = '{
        '{LDCOS_CMD_WRITE, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0, 11'h400, 1'b1},
        '{LDCOS_CMD_WRITE, 1'b0, LDCOS_LT_SS1, 1'b1, 1'b0, 1'b0, 11'h080, 1'b1},
        '{LDCOS_CMD_WRITE, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0, 11'h080, 1'b0},
        '{LDCOS_CMD_WRITE, 1'b0, LDCOS_LT_TG2, 1'b0, 1'b0, 1'b0, 11'h040, 1'b1},
        '{LDCOS_CMD_READ, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0, 11'h200, 1'b1},
        '{LDCOS_CMD_INHIBIT, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0, 11'h010, 1'b1},
        '{LDCOS_CMD_INHIBIT, 1'b0, LDCOS_LT_SS2, 1'b0, 1'b0, 1'b0, 11'h400, 1'b1},
        '{LDCOS_CMD_READ, 1'b0, LDCOS_LT_SS2, 1'b0, 1'b0, 1'b0, 11'h010, 1'b1},
        '{LDCOS_CMD_READ, 1'b0, LDCOS_LT_TG2, 1'b0, 1'b0, 1'b0, 11'h020, 1'b1},
        '{LDCOS_CMD_SEARCH, 1'b0, LDCOS_LT_TG1, 1'b0, 1'b0, 1'b0, 11'h020, 1'b1},
        '{LDCOS_CMD_POLL, 1'b0, LDCOS_LT_SS2, 1'b0, 1'b0, 1'b0, 11'h020, 1'b1},
        '{LDCOS_CMD_POLL, 1'b0, LDCOS_LT_SS1, 1'b1, 1'b0, 1'b0, 11'h080, 1'b1},
        '{LDCOS_CMD_POLL, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0, 11'h004, 1'b1},
        '{LDCOS_CMD_POLL, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0, 11'h00C, 1'b0},
        '{LDCOS_CMD_READ, 1'b1, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0, 11'h100, 1'b1},
        '{LDCOS_CMD_SEARCH, 1'b1, LDCOS_LT_SS1, 1'b0, 1'b1, 1'b0, 11'h400, 1'b1},
        '{LDCOS_CMD_READ, 1'b1, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0, 11'h400, 1'b0},
        '{LDCOS_CMD_READ, 1'b1, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b1, 11'h002, 1'b1},
        '{LDCOS_CMD_READ, 1'b1, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0, 11'h002, 1'b0},
        '{LDCOS_CMD_WRITE, 1'b0, LDCOS_LT_TG1, 1'b0, 1'b0, 1'b0, 11'h080, 1'b1},
        '{LDCOS_CMD_WRAP, 1'b0, LDCOS_LT_SS2, 1'b0, 1'b0, 1'b0, 11'h400, 1'b1},
        '{LDCOS_CMD_SEARCH, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0, 11'h020, 1'b0}
    };
    logic                mclk;
    logic                reset_n;
    ldcos_cmd_s_t        cmd_in;
    logic                sense_rd;
    ldcos_evt_t          evt_in;
    logic                char_valid;
    logic [CHAR_W-1:0]   char_data;
    logic                svc_req;
    logic                svc_ack;
    logic [WORD_W-1:0]   svc_data;
    logic [CHAR_W-1:0]   svc_char;
    logic [SENSE_W-1:0]  sense;
    logic [7:0]          ack_dly;
    logic                mon_on;
    logic                bsc_mode;
    logic [31:0]         exp_q[$];
    logic [31:0]         word;
    int                  num_errors;
    int                  cmp_count;
    int                  cyc;
    int unsigned         junk;
    ldcos_sense dut_u (.mclk(mclk), .reset_n(reset_n), .cmd_in(cmd_in), .sense_rd(sense_rd),
        .evt_in(evt_in), .char_valid(char_valid), .char_data(char_data), .svc_req(svc_req),
        .svc_ack(svc_ack), .svc_data(svc_data), .svc_char(svc_char), .sense(sense));
    ldcos_chan_model chan_u (.mclk(mclk), .reset_n(reset_n), .svc_req(svc_req),
        .svc_ack(svc_ack), .ack_dly(ack_dly));
    // ------------------------------------------------------------
    // Clock, timeout and tasks
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("[ERR] t=%0t run timed out", $time);
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk_sense(input logic dc, input logic ov);
        logic [7:0] e;
        e = SENSE_RESET;
        e[SENSE_DCHK_BIT] = dc;
        e[SENSE_OVRN_BIT] = ov;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check({24'h0, sense}, {24'h0, e});
    endtask
    task automatic start_cmd(input ldcos_cmd_t c, input logic b, input ldcos_line_t l,
                             input logic tg, input logic asc, input logic tr);
        @(posedge mclk);
        bsc_mode = b;
        cmd_in <= '{1'b1, c, b, l, tg, asc, tr};
        @(posedge mclk);
        cmd_in.start <= 1'b0;
    endtask
    task automatic pulse_evt(input logic [10:0] e);
        @(posedge mclk);
        evt_in <= ldcos_evt_t'(e);
        @(posedge mclk);
        evt_in <= ldcos_evt_t'(11'h000);
    endtask
    task automatic send_char(input logic [7:0] c);
        @(posedge mclk);
        char_valid <= 1'b1;
        char_data  <= c;
        @(posedge mclk);
        char_valid <= 1'b0;
    endtask
    task automatic read_sense();
        @(posedge mclk);
        sense_rd <= 1'b1;
        @(posedge mclk);
        sense_rd <= 1'b0;
    endtask
    task automatic wait_idle();
        @(negedge mclk);
        for (int i = 0; i < 60 && svc_req !== 1'b0; i++) @(negedge mclk);
        check({31'h0, svc_req}, 32'h0);
    endtask
    // Results handed to the channel are matched against the oldest note.
    always @(posedge mclk) begin
        if (reset_n && mon_on && svc_req === 1'b1 && svc_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("[ERR] t=%0t unexpected transfer", $time);
            end else if (bsc_mode) check(svc_data, exp_q.pop_front());
            else check({24'h0, svc_char}, exp_q.pop_front());
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0; cmd_in = '0; sense_rd = 1'b0; evt_in = ldcos_evt_t'(11'h000);
        char_valid = 1'b0; char_data = 8'h00; ack_dly = 8'h01; mon_on = 1'b1;
        bsc_mode = 1'b0; num_errors = 0; cmp_count = 0; cyc = 0;
        junk = $urandom(32'hB4EF);
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        pulse_evt(11'h400);
        chk_sense(1'b0, 1'b0);
        $display("test reset done");
        foreach (CASES[i]) begin
            start_cmd(CASES[i].cmd, CASES[i].bsc, CASES[i].line, CASES[i].tg, CASES[i].asc,
                      CASES[i].tr);
            pulse_evt(CASES[i].ev);
            chk_sense(CASES[i].dc, 1'b0);
            repeat (4) @(posedge mclk);
            chk_sense(CASES[i].dc, 1'b0);
            read_sense();
            chk_sense(1'b0, 1'b0);
        end
        start_cmd(LDCOS_CMD_READ, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0);
        pulse_evt(11'h400);
        start_cmd(LDCOS_CMD_READ, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0);
        chk_sense(1'b0, 1'b0);
        $display("test data check done");
        for (int k = 0; k < 4; k++) begin
            ack_dly <= 8'($urandom_range(3));
            word = {24'h0, 8'($urandom)};
            exp_q.push_back(word);
            send_char(word[7:0]);
            wait_idle();
        end
        chk_sense(1'b0, 1'b0);
        mon_on = 1'b0;
        ack_dly <= 8'hFF;
        send_char(8'($urandom));
        chk_sense(1'b0, 1'b0);
        send_char(8'($urandom));
        chk_sense(1'b0, 1'b1);
        ack_dly <= 8'h00;
        wait_idle();
        read_sense();
        $display("test start/stop overrun done");
        start_cmd(LDCOS_CMD_INHIBIT, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0);
        ack_dly <= 8'hFF;
        send_char(8'($urandom));
        pulse_evt(11'h001);
        chk_sense(1'b0, 1'b1);
        ack_dly <= 8'h00;
        wait_idle();
        read_sense();
        mon_on = 1'b1;
        start_cmd(LDCOS_CMD_INHIBIT, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0);
        word = {24'h0, 8'($urandom)};
        exp_q.push_back(word);
        send_char(word[7:0]);
        wait_idle();
        pulse_evt(11'h001);
        chk_sense(1'b0, 1'b0);
        $display("test inhibit done");
        for (int m = 0; m < 2; m++) begin
            mon_on = 1'b1;
            ack_dly <= 8'h01;
            start_cmd(m ? LDCOS_CMD_SEARCH : LDCOS_CMD_READ, 1'b1, LDCOS_LT_SS1, 1'b0, 1'b0,
                      1'b0);
            word = $urandom;
            exp_q.push_back(word);
            for (int b = 3; b >= 0; b--) send_char(word[b*8 +: 8]);
            repeat (8) @(posedge mclk);
            wait_idle();
            chk_sense(1'b0, 1'b0);
            mon_on = 1'b0;
            ack_dly <= 8'hFF;
            for (int b = 0; b < 4; b++) send_char(8'($urandom));
            repeat (8) @(posedge mclk);
            chk_sense(1'b0, 1'b0);
            for (int b = 0; b < 4; b++) send_char(8'($urandom));
            repeat (8) @(posedge mclk);
            chk_sense(1'b0, 1'b1);
            ack_dly <= 8'h00;
            wait_idle();
            read_sense();
        end
        $display("test synchronous overrun done");
        start_cmd(LDCOS_CMD_READ, 1'b0, LDCOS_LT_SS1, 1'b0, 1'b0, 1'b0);
        pulse_evt(11'h400);
        chk_sense(1'b1, 1'b0);
        @(posedge mclk);
        reset_n <= 1'b0;
        chk_sense(1'b0, 1'b0);
        @(posedge mclk);
        reset_n <= 1'b1;
        chk_sense(1'b0, 1'b0);
        check({31'h0, svc_req}, 32'h0);
        start_cmd(LDCOS_CMD_READ, 1'b0, LDCOS_LT_SS2, 1'b0, 1'b0, 1'b0);
        pulse_evt(11'h400);
        chk_sense(1'b1, 1'b0);
        $display("test mid-run reset done");
        check(32'(exp_q.size()), 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
